// >>> src/low_power_rc_osc_osc_tick.sv
// Low-power oscillator model: one tick per 32 kHz period while enabled.
`timescale 1ns/10ps
module osc_tick_gen
  import wdt_pkg::*;
(
  input wire logic clk_sys,  // System clock.
  input wire logic rst_n,    // Asynchronous reset, active low.
  input wire logic clk_en,   // Freezes all state while low.
  input wire logic osc_on,   // Oscillator runs while high.
  output logic tick          // One-cycle pulse per oscillator period.
);

  logic [OSC_CNT_W-1:0] cnt_q;
  logic [OSC_CNT_W-1:0] cnt_d;
  logic tick_q;
  logic tick_d;

  // ****************************************************************
  // Period divider
  // ****************************************************************

  // A stopped oscillator restarts its period from zero.
  always_comb
  begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (!osc_on)
    begin
      cnt_d = OSC_CNT_RESET;
    end
    else if (cnt_q == OSC_CNT_LAST)
    begin
      cnt_d = OSC_CNT_RESET;
      tick_d = 1'b1;
    end
    else
    begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  // Registers the divider.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= OSC_CNT_RESET;
      tick_q <= 1'b0;
    end
    else if (clk_en)
    begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule // osc_tick_gen

// >>> src/wdt_pkg.sv
// Shared constants and carrier types for the windowed watchdog timer.
package wdt_pkg;

  // ****************************************************************
  // Clock rates and derived cycle counts
  // ****************************************************************
  localparam int unsigned CLK_SYS_FREQ_KHZ = 40000;
  localparam int unsigned OSC_FREQ_KHZ = 32;
  // System clock cycles per low-power oscillator period (1250 at 40 MHz).
  localparam int unsigned OSC_DIV_CYCLES = CLK_SYS_FREQ_KHZ / OSC_FREQ_KHZ;
  localparam int unsigned OSC_CNT_W = $clog2(OSC_DIV_CYCLES);
  localparam logic [OSC_CNT_W-1:0] OSC_CNT_LAST = OSC_CNT_W'(OSC_DIV_CYCLES - 1);
  localparam logic [OSC_CNT_W-1:0] OSC_CNT_RESET = '0;

  // ****************************************************************
  // Prescaler, postscaler and window widths
  // ****************************************************************
  localparam int unsigned PRE_W = 7;
  localparam int unsigned POST_W = 15;
  localparam int unsigned ELAPSED_W = PRE_W + POST_W;
  localparam int unsigned PERIOD_W = ELAPSED_W + 1;
  localparam logic [PRE_W-1:0] PRE_LAST_DIV32 = 7'h1f;
  localparam logic [PRE_W-1:0] PRE_LAST_DIV128 = 7'h7f;
  localparam logic [PERIOD_W-1:0] PRE_RATIO_DIV32 = 23'h000020;
  localparam logic [PERIOD_W-1:0] PRE_RATIO_DIV128 = 23'h000080;
  localparam logic [PRE_W-1:0] PRE_CNT_RESET = '0;
  localparam logic [POST_W-1:0] POST_CNT_RESET = '0;
  localparam int unsigned WIN_SHIFT = 3;

  // ****************************************************************
  // Configuration word layout
  // ****************************************************************
  localparam int unsigned CFG_POSTSCALE_LSB = 0;
  localparam int unsigned CFG_PRESCALE_BIT = 4;
  localparam int unsigned CFG_WINDOW_DISABLE_BIT = 6;
  localparam int unsigned CFG_HW_ON_BIT = 7;
  localparam int unsigned CFG_WINDOW_SELECT_LSB = 8;

  typedef struct packed {
    logic [5:0] unused_hi;       // Bits 15:10, ignored.
    logic [1:0] window_select;   // Bits 9:8.
    logic hw_watchdog_on;        // Bit 7.
    logic window_disable;        // Bit 6.
    logic unused_5;              // Bit 5, ignored.
    logic prescale_select;       // Bit 4, 1 selects divide by 128.
    logic [3:0] postscale_select; // Bits 3:0.
  } watchdog_config_word_t;

  // ****************************************************************
  // Status and control register layout
  // ****************************************************************
  localparam int unsigned STAT_W = 16;
  localparam int unsigned STAT_IDLE_BIT = 2;
  localparam int unsigned STAT_SLEEP_BIT = 3;
  localparam int unsigned STAT_TIMEOUT_BIT = 4;
  localparam int unsigned STAT_SW_ON_BIT = 5;
  localparam logic [STAT_W-1:0] STAT_RESET = 16'h0000;

  // ****************************************************************
  // Core event pulses
  // ****************************************************************
  typedef struct packed {
    logic device_reset;         // Any device reset other than power-on.
    logic clock_switch_done;    // Software or fail-safe clock switch finished.
    logic power_save_instr;     // Enter sleep or idle.
    logic power_save_idle;      // Qualifies power_save_instr: 1 idle, 0 sleep.
    logic power_save_exit;      // Another wake source ends sleep or idle.
    logic clear_watchdog_instr; // Watchdog clear instruction executed.
  } wdt_events_t;

  // ****************************************************************
  // Power state
  // ****************************************************************
  typedef enum logic [1:0] {
    PS_RUN = 2'b00,
    PS_SLEEP = 2'b01,
    PS_IDLE = 2'b10
  } power_state_t;

  // Closed part of the window in eighths of the period, per window_select.
  localparam logic [3:0] WIN_CLOSED_EIGHTHS_0 = 4'h6;
  localparam logic [3:0] WIN_CLOSED_EIGHTHS_1 = 4'h4;
  localparam logic [3:0] WIN_CLOSED_EIGHTHS_2 = 4'h2;
  localparam logic [3:0] WIN_CLOSED_EIGHTHS_3 = 4'h1;

endpackage

// >>> src/windowed_watchdog_timer.sv
// Windowed watchdog timer with prescaler, postscaler and power-save wake.
`timescale 1ns/10ps

// Contract
// - Watchdog counts low-power oscillator ticks; enabling the watchdog starts the oscillator.
// - The oscillator runs at a nominal 32 kHz and sets the timeout rate.
// - Prescaler divides by 32 or 128, chosen by prescale_select.
// - Four-bit postscale_select picks sixteen postscaler ratios, 1:1 to 1:32768.
// - Any device reset clears the watchdog, prescaler and postscaler.
// - A completed clock switch clears the watchdog, prescaler and postscaler.
// - Entering sleep or idle clears the watchdog, prescaler and postscaler.
// - Leaving sleep or idle clears the watchdog, prescaler and postscaler.
// - The clear instruction in normal run clears all watchdog counts.
// - The watchdog runs in sleep and idle; its timeout wakes the core.
// - hw_watchdog_on high keeps the watchdog enabled regardless of software.
// - With hw_watchdog_on low, the watchdog runs only while sw_watchdog_on is set.
// - Every device reset clears sw_watchdog_on.
// - Timeout sets a sticky flag that only software clears.
// - window_disable low turns windowed clearing on.
module windowed_watchdog_timer
  import wdt_pkg::*;
#(
  parameter logic [3:0] WIN_CLOSED_0 = WIN_CLOSED_EIGHTHS_0, // Closed eighths, window_select 0.
  parameter logic [3:0] WIN_CLOSED_1 = WIN_CLOSED_EIGHTHS_1, // Closed eighths, window_select 1.
  parameter logic [3:0] WIN_CLOSED_2 = WIN_CLOSED_EIGHTHS_2, // Closed eighths, window_select 2.
  parameter logic [3:0] WIN_CLOSED_3 = WIN_CLOSED_EIGHTHS_3  // Closed eighths, window_select 3.
)
(
  input wire logic clk_sys,                          // System clock, 40 MHz.
  input wire logic rst_n,                            // Power-on reset, asynchronous, active low.
  input wire logic clk_en,                           // Freezes all state while low.
  input wire watchdog_config_word_t watchdog_config_word, // Configuration word.
  input wire wdt_events_t events,                    // Core event pulses.
  input wire logic status_wr,                        // Software write strobe for the status register.
  input wire logic [STAT_W-1:0] status_wdata,        // Software write data.
  output logic [STAT_W-1:0] reset_control_reg,       // Status register read value.
  output logic wdt_reset_req,                        // One-cycle device reset request.
  output logic wdt_wake,                             // One-cycle wake pulse out of sleep or idle.
  output logic low_power_rc_osc_on,                  // Oscillator enable.
  output logic watchdog_running,                     // Watchdog enabled.
  output logic window_open,                          // A clear in the previous cycle would have been accepted; lags the clear check by one cycle.
  output power_state_t power_state                   // Current power state.
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic osc_tick;
  logic enabled;
  logic [PRE_W-1:0] pre_cnt_q;
  logic [PRE_W-1:0] pre_cnt_d;
  logic [POST_W-1:0] post_cnt_q;
  logic [POST_W-1:0] post_cnt_d;
  logic [PRE_W-1:0] pre_last;
  logic [POST_W-1:0] post_last;
  logic [PERIOD_W-1:0] pre_ratio;
  logic [PERIOD_W-1:0] period;
  logic [PERIOD_W-1:0] elapsed;
  logic [PERIOD_W-1:0] closed_limit;
  logic [3:0] closed_eighths;
  logic timeout;
  logic windowed;
  logic early_clear;
  logic run_clear;
  logic wake_now;
  logic counts_clear;
  power_state_t state_q;
  power_state_t state_d;
  logic sw_on_q;
  logic sw_on_d;
  logic flag_q;
  logic flag_d;
  logic sleep_bit_q;
  logic sleep_bit_d;
  logic idle_bit_q;
  logic idle_bit_d;
  logic reset_req_q;
  logic reset_req_d;
  logic wake_q;
  logic wake_d;
  logic osc_on_q;
  logic window_open_q;
  logic window_open_d;

  // ****************************************************************
  // Enable and oscillator
  // ****************************************************************

  // Hardware enable overrides the software bit.
  assign enabled = watchdog_config_word.hw_watchdog_on | sw_on_q;

  // The oscillator runs whenever the watchdog is enabled.
  osc_tick_gen osc_tick_gen_i (
    .clk_sys (clk_sys),
    .rst_n (rst_n),
    .clk_en (clk_en),
    .osc_on (enabled),
    .tick (osc_tick)
  );

  // ****************************************************************
  // Scaler terminal counts and window limit
  // ****************************************************************

  // Terminal counts, elapsed ticks and the closed part of the window.
  always_comb
  begin
    pre_last = watchdog_config_word.prescale_select ? PRE_LAST_DIV128 : PRE_LAST_DIV32;
    pre_ratio = watchdog_config_word.prescale_select ? PRE_RATIO_DIV128 : PRE_RATIO_DIV32;
    post_last = POST_W'((17'h00001 << watchdog_config_word.postscale_select) - 17'h00001);
    period = PERIOD_W'(pre_ratio << watchdog_config_word.postscale_select);
    if (watchdog_config_word.prescale_select)
    begin
      elapsed = PERIOD_W'({post_cnt_q, pre_cnt_q});
    end
    else
    begin
      elapsed = PERIOD_W'({post_cnt_q, pre_cnt_q[4:0]});
    end
    unique case (watchdog_config_word.window_select)
      2'b00: closed_eighths = WIN_CLOSED_0;
      2'b01: closed_eighths = WIN_CLOSED_1;
      2'b10: closed_eighths = WIN_CLOSED_2;
      2'b11: closed_eighths = WIN_CLOSED_3;
    endcase
    closed_limit = PERIOD_W'((period >> WIN_SHIFT) * closed_eighths);
  end

  // ****************************************************************
  // Event decode
  // ****************************************************************

  // Timeout fires on the tick that would pass both terminal counts.
  assign timeout = enabled & osc_tick & (pre_cnt_q == pre_last) & (post_cnt_q == post_last);
  assign windowed = ~watchdog_config_word.window_disable;
  assign run_clear = events.clear_watchdog_instr & (state_q == PS_RUN) & enabled;
  assign early_clear = run_clear & windowed & (elapsed < closed_limit);
  assign wake_now = (state_q != PS_RUN) & (timeout | events.power_save_exit);

  // Every source that restarts the counts except timeout, which the scaler adds itself.
  assign counts_clear = events.device_reset
                      | events.clock_switch_done
                      | events.power_save_instr
                      | wake_now
                      | run_clear
                      | ~enabled;

  // ****************************************************************
  // Prescaler and postscaler
  // ****************************************************************

  // Counts ticks in every power state, the postscaler stepping on prescaler wrap.
  always_comb
  begin
    pre_cnt_d = pre_cnt_q;
    post_cnt_d = post_cnt_q;
    if (counts_clear || timeout)
    begin
      pre_cnt_d = PRE_CNT_RESET;
      post_cnt_d = POST_CNT_RESET;
    end
    else if (osc_tick)
    begin
      if (pre_cnt_q == pre_last)
      begin
        pre_cnt_d = PRE_CNT_RESET;
        post_cnt_d = post_cnt_q + 1'b1;
      end
      else
      begin
        pre_cnt_d = pre_cnt_q + 1'b1;
      end
    end
  end

  // Registers the scaler counts.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_cnt_q <= PRE_CNT_RESET;
      post_cnt_q <= POST_CNT_RESET;
    end
    else if (clk_en)
    begin
      pre_cnt_q <= pre_cnt_d;
      post_cnt_q <= post_cnt_d;
    end
  end

  // ****************************************************************
  // Power state
  // ****************************************************************

  // Tracks sleep and idle so that a timeout wakes instead of resetting.
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      PS_RUN:
      begin
        if (events.power_save_instr)
        begin
          state_d = events.power_save_idle ? PS_IDLE : PS_SLEEP;
        end
      end
      PS_SLEEP, PS_IDLE:
      begin
        if (wake_now)
        begin
          state_d = PS_RUN;
        end
      end
      default: state_d = PS_RUN;
    endcase
    if (events.device_reset)
    begin
      state_d = PS_RUN;
    end
  end

  // Registers the power state.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= PS_RUN;
    end
    else if (clk_en)
    begin
      state_q <= state_d;
    end
  end

  // ****************************************************************
  // Status bits and outputs
  // ****************************************************************

  // Software writes first; hardware sets win over a clear in the same cycle.
  always_comb
  begin
    sw_on_d = sw_on_q;
    flag_d = flag_q;
    sleep_bit_d = sleep_bit_q;
    idle_bit_d = idle_bit_q;
    if (status_wr)
    begin
      sw_on_d = status_wdata[STAT_SW_ON_BIT];
      flag_d = status_wdata[STAT_TIMEOUT_BIT];
      sleep_bit_d = status_wdata[STAT_SLEEP_BIT];
      idle_bit_d = status_wdata[STAT_IDLE_BIT];
    end
    if (events.device_reset)
    begin
      sw_on_d = 1'b0;
    end
    if (timeout)
    begin
      flag_d = 1'b1;
    end
    if (events.power_save_instr && (state_q == PS_RUN))
    begin
      sleep_bit_d = sleep_bit_d | ~events.power_save_idle;
      idle_bit_d = idle_bit_d | events.power_save_idle;
    end
    reset_req_d = (timeout & (state_q == PS_RUN)) | early_clear;
    wake_d = timeout & (state_q != PS_RUN);
    window_open_d = enabled & (~windowed | (elapsed >= closed_limit));
  end

  // Registers status bits and the top-level outputs.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sw_on_q <= STAT_RESET[STAT_SW_ON_BIT];
      flag_q <= STAT_RESET[STAT_TIMEOUT_BIT];
      sleep_bit_q <= STAT_RESET[STAT_SLEEP_BIT];
      idle_bit_q <= STAT_RESET[STAT_IDLE_BIT];
      reset_req_q <= 1'b0;
      wake_q <= 1'b0;
      osc_on_q <= 1'b0;
      window_open_q <= 1'b0;
    end
    else if (clk_en)
    begin
      sw_on_q <= sw_on_d;
      flag_q <= flag_d;
      sleep_bit_q <= sleep_bit_d;
      idle_bit_q <= idle_bit_d;
      reset_req_q <= reset_req_d;
      wake_q <= wake_d;
      osc_on_q <= enabled;
      window_open_q <= window_open_d;
    end
  end

  // Register bits map onto the status word; other bits read as zero.
  always_comb
  begin
    reset_control_reg = STAT_RESET;
    reset_control_reg[STAT_SW_ON_BIT] = sw_on_q;
    reset_control_reg[STAT_TIMEOUT_BIT] = flag_q;
    reset_control_reg[STAT_SLEEP_BIT] = sleep_bit_q;
    reset_control_reg[STAT_IDLE_BIT] = idle_bit_q;
  end

  assign wdt_reset_req = reset_req_q;
  assign wdt_wake = wake_q;
  assign low_power_rc_osc_on = osc_on_q;
  assign watchdog_running = osc_on_q;
  assign window_open = window_open_q;
  assign power_state = state_q;

endmodule // windowed_watchdog_timer

// >>> verif/testbench.sv
// Self-checking bench for the windowed watchdog timer.
`timescale 1ns/10ps
module testbench
  import wdt_pkg::*;
;
  localparam int PERIOD = 32 * OSC_DIV_CYCLES;
  localparam int WIN = (32 / 8) * int'(WIN_CLOSED_EIGHTHS_3) * OSC_DIV_CYCLES;
  logic clk_sys, rst_n, clk_en, status_wr;
  logic [STAT_W-1:0] status_wdata, reset_control_reg;
  watchdog_config_word_t watchdog_config_word;
  wdt_events_t events;
  logic wdt_reset_req, wdt_wake, low_power_rc_osc_on, watchdog_running, window_open;
  power_state_t power_state;
  int failures, checks, n;

  windowed_watchdog_timer windowed_watchdog_timer_i (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .watchdog_config_word(watchdog_config_word), .events(events), .status_wr(status_wr),
    .status_wdata(status_wdata),
    .reset_control_reg(reset_control_reg), .wdt_reset_req(wdt_reset_req), .wdt_wake(wdt_wake),
    .low_power_rc_osc_on(low_power_rc_osc_on), .watchdog_running(watchdog_running),
    .window_open(window_open), .power_state(power_state));

  // ****************************************************************
  // Clock and access tasks
  // ****************************************************************
  // The 40 MHz clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Inputs always change 2 ns after a rising edge.
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #2;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // The oscillator phase is free, so a wait may end up to one tick early.
  task automatic near(input int e);
    check(16'(n >= e - OSC_DIV_CYCLES - 8 && n <= e + 8), 16'h0001);
  endtask
  task automatic wr(input logic [15:0] d);
    status_wr = 1'b1;
    status_wdata = d;
    tick(1);
    status_wr = 1'b0;
  endtask
  // Event bits, high to low: reset, switch, save, idle, exit, clear.
  task automatic ev(input logic [5:0] v);
    events = wdt_events_t'(v);
    tick(1);
    events = '0;
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Waits for reset request (0), wake (1) or open window (2), with a limit.
  task automatic wait_out(input int sel, input int lim);
    n = 0;
    while (((sel == 0) ? wdt_reset_req : (sel == 1) ? wdt_wake : window_open) !== 1'b1)
    begin
      tick(1);
      n++;
      if (n >= lim)
      begin
        failures++;
        test_done();
      end
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    failures = 0;
    checks = 0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    status_wr = 1'b0;
    status_wdata = 16'h0000;
    events = '0;
    watchdog_config_word = 16'h0340;
    tick(4);
    rst_n = 1'b1;
    check(reset_control_reg, 16'h0000);
    check(16'(watchdog_running), 16'h0000);
    // A frozen clock enable ignores the write.
    clk_en = 1'b0;
    wr(16'h0020);
    tick(1);
    check(reset_control_reg, 16'h0000);
    clk_en = 1'b1;
    // Software enable, then a full run-mode timeout at divide by 32, ratio 1:1.
    wr(16'h0020);
    check(reset_control_reg, 16'h0020);
    tick(1);
    check(16'(low_power_rc_osc_on), 16'h0001);
    wait_out(0, PERIOD + 2000);
    near(PERIOD);
    check(reset_control_reg, 16'h0030);
    tick(5);
    check(reset_control_reg, 16'h0030);
    wr(16'h0020);
    check(reset_control_reg, 16'h0020);
    // Windowed mode: an early clear resets without setting the flag.
    watchdog_config_word = 16'h0300;
    tick(1);
    check(16'(window_open), 16'h0000);
    ev(6'h01);
    check(16'(wdt_reset_req), 16'h0001);
    check(reset_control_reg, 16'h0020);
    tick(1);
    check(16'(window_open), 16'h0000);
    wait_out(2, WIN + 2000);
    near(WIN);
    ev(6'h01);
    check(16'(wdt_reset_req), 16'h0000);
    tick(1);
    check(16'(window_open), 16'h0000);
    // A finished clock switch closes the window again.
    wait_out(2, WIN + 2000);
    ev(6'h10);
    tick(1);
    check(16'(window_open), 16'h0000);
    // Sleep entry and exit; the status bit stays until software clears it.
    ev(6'h08);
    check(16'(power_state), 16'(PS_SLEEP));
    check(reset_control_reg, 16'h0028);
    tick(1);
    ev(6'h02);
    check(16'(power_state), 16'(PS_RUN));
    check(reset_control_reg, 16'h0028);
    tick(1);
    check(16'(window_open), 16'h0000);
    wr(16'h0020);
    check(reset_control_reg, 16'h0020);
    // Idle entry, then the timeout wakes the core instead of resetting it.
    ev(6'h0c);
    check(16'(power_state), 16'(PS_IDLE));
    check(reset_control_reg, 16'h0024);
    wait_out(1, PERIOD + 2000);
    near(PERIOD);
    check(16'(wdt_reset_req), 16'h0000);
    check(16'(power_state), 16'(PS_RUN));
    check(reset_control_reg, 16'h0034);
    wr(16'h0020);
    // A device reset drops the software enable.
    ev(6'h20);
    check(reset_control_reg, 16'h0000);
    tick(2);
    check(16'(watchdog_running), 16'h0000);
    // The configuration bit keeps the watchdog on whatever software does.
    watchdog_config_word = 16'h0380;
    tick(2);
    check(16'(watchdog_running), 16'h0001);
    wr(16'h0000);
    ev(6'h20);
    tick(2);
    check(16'(watchdog_running), 16'h0001);
    test_done();
  end
endmodule // testbench

// >>> verif/wdt_asserts.sv
// Concurrent checks on the watchdog timer ports.
`timescale 1ns/10ps
module wdt_asserts
  import wdt_pkg::*;
(
  input wire logic clk_sys, // Clock.
  input wire logic rst_n, // Reset.
  input wire logic clk_en, // Run enable.
  input wire watchdog_config_word_t watchdog_config_word, // Config.
  input wire wdt_events_t events, // Events.
  input wire logic status_wr, // Write strobe.
  input wire logic [STAT_W-1:0] status_wdata, // Write data.
  input wire logic [STAT_W-1:0] reset_control_reg, // Status.
  input wire logic wdt_reset_req, // Reset request.
  input wire logic wdt_wake, // Wake pulse.
  input wire logic low_power_rc_osc_on, // Oscillator on.
  input wire logic watchdog_running, // Enabled.
  input wire logic window_open, // Window open.
  input wire power_state_t power_state // Power state.
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // A clear in run mode while enabled and windowed.
  sequence s_win_clear;
    clk_en && events.clear_watchdog_instr && power_state == PS_RUN &&
      (watchdog_config_word.hw_watchdog_on || reset_control_reg[STAT_SW_ON_BIT]) &&
      !watchdog_config_word.window_disable;
  endsequence
  // Back in run with the timeout flag up.
  sequence s_woken;
    power_state == PS_RUN && reset_control_reg[STAT_TIMEOUT_BIT];
  endsequence
  // A timeout can only come from a running oscillator.
  a_osc_timeout: assert property ((wdt_wake || (wdt_reset_req && !$past(events.clear_watchdog_instr)))
    |-> low_power_rc_osc_on)
    else $error("timeout with oscillator stopped");
  a_enable_source: assert property ($past(clk_en && rst_n) |-> watchdog_running ==
    $past(watchdog_config_word.hw_watchdog_on || reset_control_reg[STAT_SW_ON_BIT]))
    else $error("running does not follow enable bits");
  a_sw_reset_clr: assert property (clk_en && events.device_reset |=> !reset_control_reg[STAT_SW_ON_BIT])
    else $error("software enable kept over reset");
  a_flag_sticky: assert property (clk_en && reset_control_reg[STAT_TIMEOUT_BIT] && !status_wr
    |=> reset_control_reg[STAT_TIMEOUT_BIT])
    else $error("timeout flag dropped without write");
  a_req_flag: assert property (wdt_reset_req && !$past(events.clear_watchdog_instr)
    |-> reset_control_reg[STAT_TIMEOUT_BIT])
    else $error("timeout reset without flag");
  // The window flag lags by a cycle, so an early clear shows as a reset with the window still shut.
  a_early_clear: assert property (s_win_clear ##0 !window_open |=> wdt_reset_req != window_open)
    else $error("early clear did not reset");
  // Only a settled window counts: no config change or clear in the cycle before.
  a_clear_closes: assert property (clk_en && $stable(watchdog_config_word) && $past(events) == '0 &&
    !wdt_reset_req ##0 s_win_clear ##0 window_open |=> !wdt_reset_req ##1 !window_open)
    else $error("accepted clear left window open");
  a_sleep_entry: assert property (clk_en && events.power_save_instr && power_state == PS_RUN
    |=> power_state == ($past(events.power_save_idle) ? PS_IDLE : PS_SLEEP))
    else $error("wrong power state on entry");
  a_exit_run: assert property (clk_en && events.power_save_exit && power_state != PS_RUN
    |=> power_state == PS_RUN)
    else $error("exit did not return to run");
  a_wake_run: assert property (wdt_wake |-> ($past(power_state) != PS_RUN) ##0 s_woken)
    else $error("wake outside power save");
endmodule // wdt_asserts

bind windowed_watchdog_timer wdt_asserts wdt_asserts_i (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
  .watchdog_config_word(watchdog_config_word), .events(events), .status_wr(status_wr),
  .status_wdata(status_wdata),
  .reset_control_reg(reset_control_reg), .wdt_reset_req(wdt_reset_req), .wdt_wake(wdt_wake),
  .low_power_rc_osc_on(low_power_rc_osc_on), .watchdog_running(watchdog_running),
  .window_open(window_open), .power_state(power_state));
